// ==== core/sgp_consts.vh ====
// Constants for the shared port D / port E block.
// Assumes a byte-wide CPU register port with an 8-bit address.
`ifndef SGP_CONSTS_VH
`define SGP_CONSTS_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define SGP_ADDR_W 8
`define SGP_ADDR_PORT_D_DATA 8'h03
`define SGP_ADDR_PORT_E_DATA 8'h08
`define SGP_ADDR_PORT_D_DIR 8'h07
`define SGP_ADDR_PORT_E_DIR 8'h0C
`define SGP_ADDR_PORT_D_PULLUP 8'h0D

// ----------------------------------------------------------------
// Widths, reset values and pin positions
// ----------------------------------------------------------------
`define SGP_D_W 8
`define SGP_E_W 6
`define SGP_DIR_D_RESET 8'h00
`define SGP_DIR_E_RESET 6'h00
`define SGP_PULLUP_RESET 8'h00
`define SGP_E_PAD 2'h0
`define SGP_D_UNSHARED 4'h0
`define SGP_E_UNSHARED 4'h0
`define SGP_RDATA_RESET 8'h00
`define SGP_UNMAPPED_READ 8'h00
`define SGP_D_SPI_CLK 3
`define SGP_D_SPI_MOSI 2
`define SGP_D_SPI_MISO 1
`define SGP_D_SPI_SS 0
`define SGP_E_SER_RX 1
`define SGP_E_SER_TX 0

`endif

// ==== core/sgp_ports.v ====
// Ports D (8 bits) and E (6 bits) with data latches, direction and
// port D pullup enables, sharing pins with the SPI and serial blocks.
// Assumes a synchronous CPU register port and pins synchronous to clk_i;
// each pin is split into input, output and active-low output enable.
`timescale 1ns/10ps
`default_nettype none
`include "sgp_consts.vh"

module sgp_ports (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] addr_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  input wire spi_enable_bit_i,
  input wire spi_master_select_bit_i,
  input wire serial_iface_enable_bit_i,
  input wire port_b_direction_bit0_i,
  input wire [3:0] spi_out_i,
  input wire [3:0] spi_oe_n_i,
  output wire [3:0] spi_in_o,
  input wire serial_tx_i,
  output wire serial_rx_o,
  input wire [7:0] pd_in_i,
  output wire [7:0] pd_out_o,
  output wire [7:0] pd_oe_n_o,
  output wire [7:0] pd_pullup_o,
  input wire [5:0] pe_in_i,
  output wire [5:0] pe_out_o,
  output wire [5:0] pe_oe_n_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] port_d_data_latch;
  reg [5:0] port_e_data_latch;
  reg [7:0] port_d_direction;
  reg [5:0] port_e_direction;
  reg [7:0] port_d_pullup_enable;
  wire [7:0] spi_owns;
  wire [5:0] ser_owns;
  // Address hits, shared by the write and read decode
  wire hit_d_data;
  wire hit_e_data;
  wire hit_d_dir;
  wire hit_e_dir;
  wire hit_d_pull;
  reg [7:0] next_rdata;

  // Latch on output pins, pin level on input pins
  function [7:0] sgp_mux_read;
    input [7:0] dir;
    input [7:0] latch;
    input [7:0] pin;
    begin
      sgp_mux_read = (dir & latch) | (~dir & pin);
    end
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // One compare for both paths, so writes and reads share one map
  function sgp_hit;
    input [`SGP_ADDR_W-1:0] addr;
    input [`SGP_ADDR_W-1:0] target;
    begin
      sgp_hit = (addr == target);
    end
  endfunction

  assign hit_d_data = sgp_hit(addr_i, `SGP_ADDR_PORT_D_DATA);
  assign hit_e_data = sgp_hit(addr_i, `SGP_ADDR_PORT_E_DATA);
  assign hit_d_dir = sgp_hit(addr_i, `SGP_ADDR_PORT_D_DIR);
  assign hit_e_dir = sgp_hit(addr_i, `SGP_ADDR_PORT_E_DIR);
  assign hit_d_pull = sgp_hit(addr_i, `SGP_ADDR_PORT_D_PULLUP);

  // ----------------------------------------------------------------
  // Direction and pullup registers
  // ----------------------------------------------------------------
  // Every pin leaves reset with no pullup, and as an input unless the SPI or serial block owns it
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      port_d_direction <= `SGP_DIR_D_RESET;
    end else if (wr_i && hit_d_dir) begin
      port_d_direction <= wdata_i;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      port_e_direction <= `SGP_DIR_E_RESET;
    end else if (wr_i && hit_e_dir) begin
      // Bits 7 and 6 have no storage
      port_e_direction <= wdata_i[`SGP_E_W-1:0];
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      port_d_pullup_enable <= `SGP_PULLUP_RESET;
    end else if (wr_i && hit_d_pull) begin
      port_d_pullup_enable <= wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Data latches
  // ----------------------------------------------------------------
  // No reset: contents survive it, and a write lands whatever the
  // direction, so software can prime a pin before turning it to output
  always @(posedge clk_i) begin
    if (wr_i && hit_d_data) begin
      port_d_data_latch <= wdata_i;
    end
  end

  always @(posedge clk_i) begin
    if (wr_i && hit_e_data) begin
      port_e_data_latch <= wdata_i[`SGP_E_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Pin ownership
  // ----------------------------------------------------------------
  // Slave select is only taken by an enabled slave; port B dir is unused
  assign spi_owns = {`SGP_D_UNSHARED, {3{spi_enable_bit_i}},
                     spi_enable_bit_i & ~spi_master_select_bit_i};
  assign ser_owns = {`SGP_E_UNSHARED, {2{serial_iface_enable_bit_i}}};

  // ----------------------------------------------------------------
  // Pin drive and enables
  // ----------------------------------------------------------------
  // Owned pins follow the peripheral; the direction bit then only
  // steers reads, so software cannot fight the SPI or serial driver
  genvar g;
  generate
    for (g = 0; g < `SGP_D_W; g = g + 1) begin : gen_d
      if (g <= `SGP_D_SPI_CLK) begin : gen_sh
        assign pd_out_o[g] = spi_owns[g] ? spi_out_i[g] : port_d_data_latch[g];
        assign pd_oe_n_o[g] = spi_owns[g] ? spi_oe_n_i[g] : ~port_d_direction[g];
        assign spi_in_o[g] = pd_in_i[g];
      end else begin : gen_pl
        assign pd_out_o[g] = port_d_data_latch[g];
        assign pd_oe_n_o[g] = ~port_d_direction[g];
      end
      // Pullup drops out whenever the pin drives
      assign pd_pullup_o[g] = port_d_pullup_enable[g] & pd_oe_n_o[g];
    end
    for (g = 0; g < `SGP_E_W; g = g + 1) begin : gen_e
      if (g == `SGP_E_SER_TX) begin : gen_tx
        assign pe_out_o[g] = ser_owns[g] ? serial_tx_i : port_e_data_latch[g];
        assign pe_oe_n_o[g] = ser_owns[g] ? 1'h0 : ~port_e_direction[g];
      end else if (g == `SGP_E_SER_RX) begin : gen_rx
        assign pe_out_o[g] = port_e_data_latch[g];
        assign pe_oe_n_o[g] = ser_owns[g] ? 1'h1 : ~port_e_direction[g];
      end else begin : gen_pl
        assign pe_out_o[g] = port_e_data_latch[g];
        assign pe_oe_n_o[g] = ~port_e_direction[g];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Peripheral inputs
  // ----------------------------------------------------------------
  // Receive sees the raw pin even while the serial block is off
  assign serial_rx_o = pe_in_i[`SGP_E_SER_RX];

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Unmapped addresses and port E bits 7 and 6 read as zero
  always @* begin
    next_rdata = `SGP_UNMAPPED_READ;
    if (hit_d_data) begin
      next_rdata = sgp_mux_read(port_d_direction, port_d_data_latch, pd_in_i);
    end else if (hit_e_data) begin
      next_rdata = sgp_mux_read({`SGP_E_PAD, port_e_direction},
                                {`SGP_E_PAD, port_e_data_latch},
                                {`SGP_E_PAD, pe_in_i});
    end else if (hit_d_dir) begin
      next_rdata = port_d_direction;
    end else if (hit_e_dir) begin
      next_rdata = {`SGP_E_PAD, port_e_direction};
    end else if (hit_d_pull) begin
      next_rdata = port_d_pullup_enable;
    end
  end

  // Registered one cycle after rd_i and held until the next read,
  // so a slow reader still sees a settled byte
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= `SGP_RDATA_RESET;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// ==== testbench/sgp_ports_properties.sv ====
// Checker for sgp_ports pin sharing, directions and reads.
// Bound to sgp_ports; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module sgp_ports_chk (
  input wire logic clk_i, rst_i, wr_i, rd_i, serial_tx_i, serial_rx_o,
  input wire logic spi_enable_bit_i, spi_master_select_bit_i,
  input wire logic serial_iface_enable_bit_i, port_b_direction_bit0_i,
  input wire logic [7:0] addr_i, wdata_i, rdata_o, pd_in_i, pd_out_o,
  input wire logic [7:0] pd_oe_n_o, pd_pullup_o,
  input wire logic [3:0] spi_out_i, spi_oe_n_i, spi_in_o,
  input wire logic [5:0] pe_in_i, pe_out_o, pe_oe_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rd_d; rd_i && !wr_i && addr_i == 8'h03; endsequence
  sequence s_rd_e; rd_i && !wr_i && addr_i == 8'h08; endsequence
  a_dir_reset: assert property (
    $fell(rst_i) |-> pd_oe_n_o[7:4] == 4'hF && pe_oe_n_o[5:2] == 4'hF) else $error("dir");
  a_pullup_gate: assert property (
    (pd_pullup_o & ~pd_oe_n_o) == 8'h00) else $error("pullup");
  a_dir_write: assert property (
    wr_i && addr_i == 8'h07 |=> pd_oe_n_o[7:4] == ~$past(wdata_i[7:4])) else $error("ddr");
  a_read_d: assert property (s_rd_d |=> rdata_o[7:4] ==
    ((~$past(pd_oe_n_o[7:4]) & $past(pd_out_o[7:4])) |
     ($past(pd_oe_n_o[7:4]) & $past(pd_in_i[7:4]))))
    else $error("rd d");
  a_read_e: assert property (s_rd_e |=> rdata_o[7:6] == 2'h0 &&
    rdata_o[5:2] == ((~$past(pe_oe_n_o[5:2]) & $past(pe_out_o[5:2])) |
                     ($past(pe_oe_n_o[5:2]) & $past(pe_in_i[5:2]))))
    else $error("rd e");
  a_spi_pins: assert property (spi_enable_bit_i |->
    pd_oe_n_o[3:1] == spi_oe_n_i[3:1] && pd_out_o[3:1] == spi_out_i[3:1]) else $error("spi");
  a_ss_owner: assert property (
    spi_enable_bit_i && !spi_master_select_bit_i |-> pd_oe_n_o[0] == spi_oe_n_i[0]) else $error("ss");
  a_ss_bdir: assert property (
    spi_enable_bit_i && $changed(port_b_direction_bit0_i) |-> $stable(pd_oe_n_o[0])) else $error("b0");
  a_ser_pins: assert property (serial_iface_enable_bit_i |-> pe_oe_n_o[1] &&
    !pe_oe_n_o[0] && pe_out_o[0] == serial_tx_i && serial_rx_o == pe_in_i[1]) else $error("sci");
  a_spi_input: assert property (spi_in_o == pd_in_i[3:0]) else $error("spi in");
endmodule
`default_nettype wire

// ==== testbench/sgp_pins.sv ====
// Pin model: resolves each pad from drive, port D pullup and outside level.
// Outside levels come from the bench.
`timescale 1ns/10ps
`default_nettype none
module sgp_pins (
  input wire logic [7:0] pd_out_o, pd_oe_n_o, pd_pullup_o, ext_d,
  input wire logic [5:0] pe_out_o, pe_oe_n_o, ext_e,
  output wire logic [7:0] pd_in_i,
  output wire logic [5:0] pe_in_i
);
  // Outside source is weak, so a pullup wins
  assign pd_in_i = (~pd_oe_n_o & pd_out_o) | (pd_oe_n_o & (pd_pullup_o | ext_d));
  assign pe_in_i = (~pe_oe_n_o & pe_out_o) | (pe_oe_n_o & ext_e);
endmodule
`default_nettype wire

// ==== testbench/tb_sgp_ports.sv ====
// Bench for sgp_ports: register access tasks and pin checks.
// Pins resolved by sgp_pins; checker bound below.
`timescale 1ns/10ps
`default_nettype none
module tb_sgp_ports;
  logic clk_i, rst_i, wr_i, rd_i, serial_tx_i, spi_enable_bit_i, spi_master_select_bit_i;
  logic serial_iface_enable_bit_i, port_b_direction_bit0_i;
  logic [7:0] addr_i, wdata_i, ext_d;
  logic [3:0] spi_out_i, spi_oe_n_i;
  logic [5:0] ext_e;
  wire logic [7:0] rdata_o, pd_in_i, pd_out_o, pd_oe_n_o, pd_pullup_o;
  wire logic [3:0] spi_in_o;
  wire logic serial_rx_o;
  wire logic [5:0] pe_in_i, pe_out_o, pe_oe_n_o;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  sgp_ports sgp_ports_i (.*);
  sgp_pins sgp_pins_i (.*);
  initial begin
    clk_i = 0;
    forever #20 clk_i = ~clk_i;
  end
  task chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("ERROR %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1 addr_i = a;
    wdata_i = d;
    wr_i = w;
    rd_i = !w;
    @(posedge clk_i);
    #1 wr_i = 0;
    rd_i = 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    xfer(0, a, 8'h00);
    chk(rdata_o, e);
  endtask
  task end_sim;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Ceiling well above the ~50 cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    {wr_i, rd_i, serial_tx_i, spi_enable_bit_i, spi_master_select_bit_i} = 5'h00;
    {serial_iface_enable_bit_i, port_b_direction_bit0_i} = 2'h0;
    {addr_i, wdata_i, spi_out_i, spi_oe_n_i} = 24'h00000F;
    ext_d = 8'h3C;
    ext_e = 6'h2A;
    rst_i = 1;
    repeat (12) @(posedge clk_i);
    #1 rst_i = 0;
    rd(8'h07, 8'h00);
    rd(8'h0C, 8'h00);
    rd(8'h0D, 8'h00);
    $display("test reset done");
    xfer(1, 8'h03, 8'hA5);
    rd(8'h03, 8'h3C);
    chk({4'h0, spi_in_o}, 8'h0C);
    xfer(1, 8'h07, 8'hF0);
    rd(8'h03, 8'hAC);
    xfer(1, 8'h0D, 8'hFF);
    rd(8'h03, 8'hAF);
    chk(pd_pullup_o, 8'h0F);
    $display("test port d done");
    xfer(1, 8'h08, 8'hD5);
    xfer(1, 8'h0C, 8'hFC);
    rd(8'h0C, 8'h3C);
    rd(8'h08, 8'h16);
    rd(8'h55, 8'h00);
    $display("test port e done");
    rst_i = 1;
    repeat (2) @(posedge clk_i);
    #1 rst_i = 0;
    xfer(1, 8'h07, 8'hFF);
    rd(8'h03, 8'hA5);
    chk(pd_oe_n_o, 8'h00);
    $display("test mid reset done");
    {spi_out_i, spi_oe_n_i, spi_enable_bit_i} = 9'h14B;
    #2 chk({pd_out_o[3:0], pd_oe_n_o[3:0]}, 8'hA5);
    rd(8'h03, 8'hA5);
    port_b_direction_bit0_i = 1;
    #2 chk({7'h00, pd_oe_n_o[0]}, 8'h01);
    // Own cycle, so the slave-select hand-over is not blamed on port B
    @(posedge clk_i);
    #1 spi_master_select_bit_i = 1;
    #2 chk({7'h00, pd_oe_n_o[0]}, 8'h00);
    $display("test spi done");
    xfer(1, 8'h0C, 8'h3F);
    {serial_tx_i, serial_iface_enable_bit_i} = 2'h3;
    #2 chk({5'h00, serial_rx_o, pe_oe_n_o[1:0]}, 8'h06);
    chk({7'h00, pe_out_o[0]}, 8'h01);
    $display("test serial done");
    end_sim();
  end
endmodule
bind sgp_ports sgp_ports_chk sgp_ports_chk_i (.*);
`default_nettype wire
